// ===== can_msgbuf.sv
// Message buffer control registers and buffer memory behind an AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
module can_msgbuf (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic tx_grant_valid,
   output logic [2:0] tx_grant_buffer,
   input wire logic tx_done,
   input wire logic tx_abort,
   input wire logic tx_lost,
   input wire logic tx_error,
   input wire logic [2:0] tx_event_buffer,
   input wire logic tx_fetch,
   input wire logic [4:0] tx_fetch_buffer,
   input wire logic [2:0] tx_fetch_word,
   output logic [15:0] tx_fetch_data,
   output logic tx_frame_extended,
   output logic tx_frame_srr,
   output logic tx_frame_rtr,
   output logic [3:0] tx_frame_length,
   input wire logic rx_word_valid,
   input wire logic [4:0] rx_word_buffer,
   input wire logic [2:0] rx_word_index,
   input wire logic [15:0] rx_word_data,
   input wire logic rx_store,
   input wire logic [4:0] rx_store_buffer,
   input wire logic [4:0] rx_store_filter,
   input wire logic rx_remote,
   input wire logic [2:0] rx_remote_buffer
);
   import can_msgbuf_pkg::*;

   logic [15:0] ram [NUM_BUFFERS*WORDS_PER_BUFFER];
   logic [7:0] ctl [NUM_CTL_BUFFERS];
   logic aw_held;
   logic w_held;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic do_write;
   acc_kind_t wr_kind;
   acc_kind_t rd_kind;
   logic [7:0] wr_ram_idx;
   logic [2:0] rd_word_q;
   logic [NUM_CTL_BUFFERS-1:0] sw_req_set;
   logic [NUM_CTL_BUFFERS-1:0] hw_req_set;
   logic [NUM_CTL_BUFFERS-1:0] pending;
   logic next_valid;
   logic [2:0] next_buffer;
   logic [1:0] best_prio;
   // Arbiter inputs one cycle late, lined up with the registered grant for checking
   logic [NUM_CTL_BUFFERS-1:0] pending_q;
   logic [1:0] prio_q [NUM_CTL_BUFFERS];

   function automatic acc_kind_t decode(input logic [11:0] a);
      if (a[11:4] == CTL_BASE[11:4])
         decode = KIND_CTL;
      else if (a[11:10] == RAM_BASE[11:10])
         decode = KIND_RAM;
      else
         decode = KIND_NONE;
   endfunction

   function automatic logic [15:0] word_mask(input logic [2:0] w);
      case (w)
         WORD_SID: word_mask = SID_MASK;
         WORD_EID: word_mask = EID_MASK;
         WORD_DLC: word_mask = DLC_MASK;
         WORD_STAT: word_mask = STAT_MASK;
         default: word_mask = DATA_MASK;
      endcase
   endfunction

   assign wr_kind = decode(wr_addr);
   assign wr_ram_idx = wr_addr[9:2];
   // Engine writes own the memory port; a bus write waits for as long as one is active
   assign do_write = aw_held && w_held && !s_axi_bvalid && !rx_word_valid && !rx_store;

   // Write channels are taken independently, response follows both
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         wr_addr <= 12'h000;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_kind == KIND_NONE) ? RESP_DECERR : RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Buffer memory; no reset, contents are undefined until written
   always_ff @(posedge ref_clk) begin
      if (rx_word_valid) begin
         ram[{rx_word_buffer, rx_word_index}] <= rx_word_data & word_mask(rx_word_index);
      end else if (rx_store) begin
         // Buffers above the control range are receive only
         if (rx_store_buffer[4:3] != 2'b00 || !ctl[rx_store_buffer[2:0]][CTL_DIR_BIT]) begin
            ram[{rx_store_buffer, WORD_STAT}] <= {3'b000, rx_store_filter, 8'h00};
         end
      end else if (do_write && wr_kind == KIND_RAM) begin
         // Lanes merge into the stored word, then unwritable bits are forced to zero
         ram[wr_ram_idx] <= {wr_strb[1] ? wr_data[15:8] : ram[wr_ram_idx][15:8],
                             wr_strb[0] ? wr_data[7:0] : ram[wr_ram_idx][7:0]}
                            & word_mask(wr_ram_idx[2:0]);
      end
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
         rd_kind <= KIND_NONE;
         rd_word_q <= 3'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            rd_kind <= decode(s_axi_araddr);
            rd_word_q <= s_axi_araddr[4:2];
            case (decode(s_axi_araddr))
               KIND_CTL: begin
                  s_axi_rresp <= RESP_OKAY;
                  // Compared one bit wider, since the register count needs three bits
                  if ({1'b0, s_axi_araddr[3:2]} < 3'(CTL_REGS))
                     s_axi_rdata <= {16'h0000, ctl[{s_axi_araddr[3:2], 1'b1}],
                                     ctl[{s_axi_araddr[3:2], 1'b0}]};
                  else
                     s_axi_rdata <= 32'h0000_0000;
               end
               KIND_RAM: begin
                  s_axi_rresp <= RESP_OKAY;
                  s_axi_rdata <= {16'h0000, ram[s_axi_araddr[9:2]]};
               end
               default: begin
                  s_axi_rresp <= RESP_DECERR;
                  s_axi_rdata <= 32'h0000_0000;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // One clock domain: every check below, the per-buffer ones too, shares it
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Per-buffer control byte for buffers 0 to 7
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CTL_BUFFERS; gi++) begin : g_ctl
         logic hit;
         logic [7:0] wbyte;
         logic clr_req;
         assign hit = do_write && wr_kind == KIND_CTL && wr_addr[3:2] == 2'(gi / 2)
                      && wr_strb[gi % 2];
         assign wbyte = wr_data[(gi % 2)*8 +: 8];
         assign sw_req_set[gi] = hit && wbyte[CTL_REQ_BIT];
         assign hw_req_set[gi] = rx_remote && rx_remote_buffer == 3'(gi)
                                 && ctl[gi][CTL_DIR_BIT] && ctl[gi][CTL_ARR_BIT];
         assign clr_req = (hit && !wbyte[CTL_REQ_BIT]) || (tx_done && tx_event_buffer == 3'(gi));
         assign pending[gi] = ctl[gi][CTL_REQ_BIT] && ctl[gi][CTL_DIR_BIT];

         always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
               ctl[gi] <= CTL_RESET;
            end else begin
               if (hit) begin
                  ctl[gi][CTL_DIR_BIT] <= wbyte[CTL_DIR_BIT];
                  ctl[gi][CTL_ARR_BIT] <= wbyte[CTL_ARR_BIT];
                  ctl[gi][1:0] <= wbyte[1:0];
               end
               // A new request wins over a same-cycle completion
               if (sw_req_set[gi] || hw_req_set[gi])
                  ctl[gi][CTL_REQ_BIT] <= 1'b1;
               else if (clr_req)
                  ctl[gi][CTL_REQ_BIT] <= 1'b0;
               // Event sets win over the clear caused by a new request
               if (tx_abort && tx_event_buffer == 3'(gi))
                  ctl[gi][CTL_ABORT_BIT] <= 1'b1;
               else if (sw_req_set[gi] || hw_req_set[gi])
                  ctl[gi][CTL_ABORT_BIT] <= 1'b0;
               if (tx_lost && tx_event_buffer == 3'(gi))
                  ctl[gi][CTL_LOST_BIT] <= 1'b1;
               else if (sw_req_set[gi] || hw_req_set[gi])
                  ctl[gi][CTL_LOST_BIT] <= 1'b0;
               if (tx_error && tx_event_buffer == 3'(gi))
                  ctl[gi][CTL_ERR_BIT] <= 1'b1;
               else if (sw_req_set[gi] || hw_req_set[gi])
                  ctl[gi][CTL_ERR_BIT] <= 1'b0;
            end
         end

         a_flags_on_request: assert property (
            sw_req_set[gi] && !tx_abort && !tx_lost && !tx_error
            |=> ctl[gi][6:4] == 3'b000)
            else $error("flags not cleared by send request");
         a_done_clears_req: assert property (
            tx_done && tx_event_buffer == 3'(gi) && !sw_req_set[gi] && !hw_req_set[gi]
            |=> !ctl[gi][CTL_REQ_BIT])
            else $error("send request not cleared on completion");
         a_remote_sets_req: assert property (
            hw_req_set[gi] |=> ctl[gi][CTL_REQ_BIT])
            else $error("remote frame did not queue reply");
         a_event_sets_flag: assert property (
            tx_lost && tx_event_buffer == 3'(gi) |=> ctl[gi][CTL_LOST_BIT])
            else $error("lost arbitration not flagged");
         // No pending buffer may outrank the buffer that was granted
         a_grant_top_prio: assert property (
            pending_q[gi] |-> tx_grant_valid && prio_q[gi] <= prio_q[tx_grant_buffer])
            else $error("grant not highest priority");
      end
   endgenerate

   // Highest priority wins; ties go to the lower buffer number
   always_comb begin
      next_valid = 1'b0;
      next_buffer = 3'h0;
      best_prio = 2'b00;
      for (int i = 0; i < NUM_CTL_BUFFERS; i++) begin
         if (pending[i] && (!next_valid || ctl[i][1:0] > best_prio)) begin
            next_valid = 1'b1;
            next_buffer = 3'(i);
            best_prio = ctl[i][1:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_grant_valid <= 1'b0;
         tx_grant_buffer <= 3'h0;
      end else begin
         tx_grant_valid <= next_valid;
         tx_grant_buffer <= next_buffer;
      end
   end

   // Checking aid only; no reset, the disable condition masks the checks during reset
   always_ff @(posedge ref_clk) begin
      pending_q <= pending;
      for (int i = 0; i < NUM_CTL_BUFFERS; i++) begin
         prio_q[i] <= ctl[i][1:0];
      end
   end

   // Engine fetch port with decoded frame fields
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_fetch_data <= 16'h0000;
         tx_frame_extended <= 1'b0;
         tx_frame_srr <= 1'b0;
         tx_frame_rtr <= 1'b0;
         tx_frame_length <= 4'h0;
      end else if (tx_fetch) begin
         tx_fetch_data <= ram[{tx_fetch_buffer, tx_fetch_word}];
         if (tx_fetch_word == WORD_SID) begin
            tx_frame_extended <= ram[{tx_fetch_buffer, WORD_SID}][SID_IDE_BIT];
            tx_frame_srr <= ram[{tx_fetch_buffer, WORD_SID}][SID_SRR_BIT];
         end
         if (tx_fetch_word == WORD_DLC) begin
            tx_frame_rtr <= ram[{tx_fetch_buffer, WORD_DLC}][DLC_RTR_BIT];
            tx_frame_length <= ram[{tx_fetch_buffer, WORD_DLC}][3:0];
         end
      end
   end

   a_dir_after_reset: assert property (
      $rose(rst_b) |-> ctl[0][CTL_DIR_BIT] == 1'b0 && !tx_grant_valid)
      else $error("buffer not receive after reset");
   a_grant_is_pending: assert property (
      tx_grant_valid |-> pending_q[tx_grant_buffer])
      else $error("granted buffer was not pending");
   a_sid_high_zero: assert property (
      s_axi_rvalid && rd_kind == KIND_RAM && rd_word_q == WORD_SID
      |-> s_axi_rdata[15:13] == 3'b000)
      else $error("identifier word upper bits not zero");
   a_eid_high_zero: assert property (
      s_axi_rvalid && rd_kind == KIND_RAM && rd_word_q == WORD_EID
      |-> s_axi_rdata[15:12] == 4'h0)
      else $error("extended word upper bits not zero");
   a_dlc_gap_zero: assert property (
      s_axi_rvalid && rd_kind == KIND_RAM && rd_word_q == WORD_DLC
      |-> s_axi_rdata[7:5] == 3'b000)
      else $error("length word gap not zero");
   a_stat_only_filter: assert property (
      s_axi_rvalid && rd_kind == KIND_RAM && rd_word_q == WORD_STAT
      |-> (s_axi_rdata[15:0] & ~STAT_MASK) == 16'h0000)
      else $error("status word spare bits not zero");
   a_filter_stored: assert property (
      rx_store && !rx_word_valid && rx_store_buffer[4:3] != 2'b00
      |=> ram[{$past(rx_store_buffer), WORD_STAT}][12:8] == $past(rx_store_filter))
      else $error("matched filter number not stored");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1] ##0 !s_axi_arready)
      else $error("read not answered next cycle");
endmodule

// ===== can_msgbuf_pkg.sv
// Constants and types for the message buffer control and buffer memory block
// Overview of operation
// - Control word packs even buffer low, odd high
// - Transmit buffers keep abort, lost, error flags
// - Setting send request clears the three flags
// - Buffer words live in shared memory array
// - Thirty-two buffers, standard id bits 12-2
// - Identifier bit 1 marks substitute remote request
// - Identifier bit 0 selects extended identifier
// - Extended word holds id 17-6 low
// - Length word bits 15-10 hold id 5-0
// - Length word bit 9 marks remote frame
// - Length word bits 3-0 give data length
// - Eight data bytes, two per word, even low
// - Stored receive writes matched filter number
// - Filter field written only for receive buffers
package can_msgbuf_pkg;
   localparam int NUM_BUFFERS = 32;
   localparam int NUM_CTL_BUFFERS = 8;
   localparam int WORDS_PER_BUFFER = 8;
   // Byte addresses on the register bus
   localparam logic [11:0] CTL_BASE = 12'h000;
   localparam logic [11:0] RAM_BASE = 12'h800;
   localparam int CTL_REGS = 4;
   // Word index within one buffer
   localparam logic [2:0] WORD_SID = 3'h0;
   localparam logic [2:0] WORD_EID = 3'h1;
   localparam logic [2:0] WORD_DLC = 3'h2;
   localparam logic [2:0] WORD_DATA0 = 3'h3;
   localparam logic [2:0] WORD_STAT = 3'h7;
   // Writable bits of each buffer word
   localparam logic [15:0] SID_MASK = 16'h1fff;
   localparam logic [15:0] EID_MASK = 16'h0fff;
   localparam logic [15:0] DLC_MASK = 16'hff1f;
   localparam logic [15:0] DATA_MASK = 16'hffff;
   localparam logic [15:0] STAT_MASK = 16'h1f00;
   // Field positions
   localparam int SID_IDE_BIT = 0;
   localparam int SID_SRR_BIT = 1;
   localparam int DLC_RTR_BIT = 9;
   localparam int STAT_FILTER_LSB = 8;
   localparam int CTL_DIR_BIT = 7;
   localparam int CTL_ABORT_BIT = 6;
   localparam int CTL_LOST_BIT = 5;
   localparam int CTL_ERR_BIT = 4;
   localparam int CTL_REQ_BIT = 3;
   localparam int CTL_ARR_BIT = 2;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {KIND_CTL, KIND_RAM, KIND_NONE} acc_kind_t;
endpackage

// ===== can_engine_model.sv
// Far-side transmit engine model that reports outcome events for the granted buffer
module can_engine_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic grant_valid,
   input wire logic [2:0] grant_buffer,
   input wire logic ev_go,
   input wire logic [1:0] ev_kind,
   output logic tx_done,
   output logic tx_abort,
   output logic tx_lost,
   output logic tx_error,
   output logic [2:0] tx_event_buffer
);
   timeunit 1ns;
   timeprecision 100ps;
   logic fire;
   assign fire = ev_go && grant_valid;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tx_done <= 1'b0;
         tx_abort <= 1'b0;
         tx_lost <= 1'b0;
         tx_error <= 1'b0;
         tx_event_buffer <= 3'h0;
      end else begin
         tx_done <= fire && ev_kind == 2'h0;
         tx_abort <= fire && ev_kind == 2'h1;
         tx_lost <= fire && ev_kind == 2'h2;
         tx_error <= fire && ev_kind == 2'h3;
         // Index scrambles outside event cycles so a stale value is never trusted
         tx_event_buffer <= fire ? grant_buffer : ~tx_event_buffer;
      end
   end
endmodule

// ===== can_message_buffer_layout_bench.sv
// Self-checking bench for the message buffer control and memory block
module can_message_buffer_layout_bench import can_msgbuf_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0, rst_b = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic tx_grant_valid, tx_done, tx_abort, tx_lost, tx_error;
   logic [2:0] tx_grant_buffer, tx_event_buffer;
   logic tx_fetch = 1'b0, tx_frame_extended, tx_frame_srr, tx_frame_rtr;
   logic [4:0] tx_fetch_buffer = 5'h0;
   logic [2:0] tx_fetch_word = 3'h0, rx_word_index = 3'h0, rx_remote_buffer = 3'h0;
   logic [15:0] tx_fetch_data, rx_word_data = 16'h0;
   logic [3:0] tx_frame_length;
   logic rx_word_valid = 1'b0, rx_store = 1'b0, rx_remote = 1'b0, ev_go = 1'b0;
   logic [4:0] rx_word_buffer = 5'h0, rx_store_buffer = 5'h0, rx_store_filter = 5'h0;
   logic [1:0] ev_kind = 2'h0;
   logic [2:0] wi [5] = '{WORD_SID, WORD_EID, WORD_DLC, WORD_DATA0, WORD_STAT};
   logic [15:0] mk [5] = '{16'h1fff, 16'h0fff, 16'hfe0f, 16'hffff, 16'h1f00};
   logic [11:0] bad_addr [2] = '{12'h010, 12'h400};
   int bad_count = 0, n_checks = 0, cyc = 0;

   can_msgbuf dut_u (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_grant_valid, .tx_grant_buffer,
      .tx_done, .tx_abort, .tx_lost, .tx_error, .tx_event_buffer, .tx_fetch,
      .tx_fetch_buffer, .tx_fetch_word, .tx_fetch_data, .tx_frame_extended, .tx_frame_srr,
      .tx_frame_rtr, .tx_frame_length, .rx_word_valid, .rx_word_buffer, .rx_word_index,
      .rx_word_data, .rx_store, .rx_store_buffer, .rx_store_filter, .rx_remote,
      .rx_remote_buffer);
   can_engine_model engine_u (.ref_clk, .rst_b, .grant_valid(tx_grant_valid),
      .grant_buffer(tx_grant_buffer), .ev_go, .ev_kind, .tx_done, .tx_abort, .tx_lost,
      .tx_error, .tx_event_buffer);

   always #12.5 ref_clk = ~ref_clk;

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      // Whole sequence needs well under a thousand cycles
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   function automatic logic [11:0] ma(input int b, input logic [2:0] w);
      return RAM_BASE + 12'(b * 32 + int'(w) * 4);
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                     output logic [1:0] resp);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic ev(input logic [1:0] k);
      @(posedge ref_clk);
      ev_kind <= k;
      ev_go <= 1'b1;
      @(posedge ref_clk);
      ev_go <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic fetch(input logic [4:0] b, input logic [2:0] w);
      @(posedge ref_clk);
      tx_fetch <= 1'b1;
      tx_fetch_buffer <= b;
      tx_fetch_word <= w;
      @(posedge ref_clk);
      tx_fetch <= 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic store(input logic [4:0] b, input logic [4:0] f);
      @(posedge ref_clk);
      rx_store <= 1'b1;
      rx_store_buffer <= b;
      rx_store_filter <= f;
      @(posedge ref_clk);
      rx_store <= 1'b0;
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(12'(4 * k), d, r);
         chk(d, 32'h0);
      end
      // Read-only flag bits are written as ones and must not stick
      wr(12'h000, 32'hfbfa, 4'h3, r);
      rd(12'h000, d, r);
      chk(d, 32'h8b8a);
      chk({28'h0, tx_grant_valid, tx_grant_buffer}, 32'h9);
      for (int k = 1; k < 4; k++) ev(2'(k));
      rd(12'h000, d, r);
      chk(d & 32'h7000, 32'h7000);
      wr(12'h000, 32'h8b8a, 4'h3, r);
      rd(12'h000, d, r);
      chk(d, 32'h8b8a);
      ev(2'h0);
      rd(12'h000, d, r);
      chk(d, 32'h838a);
      chk({28'h0, tx_grant_valid, tx_grant_buffer}, 32'h8);
      wr(12'h004, 32'h0084, 4'h3, r);
      @(posedge ref_clk);
      rx_remote <= 1'b1;
      rx_remote_buffer <= 3'h2;
      @(posedge ref_clk);
      rx_remote <= 1'b0;
      rd(12'h004, d, r);
      chk(d, 32'h008c);
      // Reserved bits of the five buffer words, the length word gap too, are written as ones and must read back as zero
      for (int k = 0; k < 5; k++) begin
         wr(ma(5, wi[k]), (wi[k] == WORD_DLC) ? 32'hfeef : 32'hffffffff, 4'h3, r);
         chk({30'h0, r}, 32'h0);
         rd(ma(5, wi[k]), d, r);
         chk(d, {16'h0, mk[k]});
      end
      wr(ma(5, WORD_DATA0), 32'h1234, 4'h3, r);
      wr(ma(5, WORD_DATA0), 32'hab00, 4'h2, r);
      rd(ma(5, WORD_DATA0), d, r);
      chk(d, 32'hab34);
      fetch(5'd5, WORD_SID);
      chk({14'h0, tx_frame_extended, tx_frame_srr, tx_fetch_data}, 32'h31fff);
      fetch(5'd5, WORD_DLC);
      chk({11'h0, tx_frame_rtr, tx_frame_length, tx_fetch_data}, 32'h1ffe0f);
      store(5'd20, 5'h0b);
      rd(ma(20, WORD_STAT), d, r);
      chk(d, 32'h0b00);
      wr(ma(0, WORD_STAT), 32'h0, 4'h3, r);
      store(5'd0, 5'h1f);
      rd(ma(0, WORD_STAT), d, r);
      chk(d, 32'h0);
      @(posedge ref_clk);
      rx_word_valid <= 1'b1;
      rx_word_buffer <= 5'd6;
      rx_word_index <= WORD_EID;
      rx_word_data <= 16'hffff;
      @(posedge ref_clk);
      rx_word_valid <= 1'b0;
      rd(ma(6, WORD_EID), d, r);
      chk(d, 32'h0fff);
      for (int k = 0; k < 2; k++) begin
         wr(bad_addr[k], 32'hffff, 4'h3, r);
         chk({30'h0, r}, 32'h3);
         rd(bad_addr[k], d, r);
         chk({d[29:0], r}, 32'h3);
      end
      close_out();
   end
endmodule
